// [rtl/sar_adc_serial_readout.v]
// serial readout sequencer of a 16-bit successive-approximation converter
// assumes select and bit clock come from a host off this clock; results from a
// core converter arrive on a valid/ready port and queue in a small fifo
// select high holds the sequencer at rest; each fall restarts it from sampling
// the core port ready flag comes from a shadow fill count so it leaves on a flop
// the lsb-first repeat reads a bit-mirrored copy of the held word
//
// Behaviour
// - falling select starts a new conversion and its serial transfer
// - first 4.5 to 5.0 bit clock periods sample the analog input
// - after fifth falling edge, enable output and drive one low null bit
// - next 16 periods shift the result out, most significant bit first
// - further clocks with select low resend result least significant first
// - after msb repeated, tri-state the output and ignore further clocks
// - new conversion only after select goes high then low again
// - serial data changes on each falling edge of the bit clock
// - power down after conversion completes and whenever select is high
// - result is straight binary, one step equals reference over 65536
// - raising select at any point ends the conversion in progress
// - select low is chip select, select high is shutdown
// - delivered bits are the oldest result waiting in the fifo, taken at the fifth falling edge
`timescale 1ns/100ps
`default_nettype none
`include "sar_adc_serial_readout_regs.vh"
module sar_adc_serial_readout #(
    parameter RESULT_BITS = `RESULT_BITS,
    parameter FIFO_DEPTH = `RESULT_FIFO_DEPTH
) (
    input wire CLK,
    input wire RST_N,
    input wire SELECT_OR_SHUTDOWN_N,
    input wire SERIAL_BIT_CLOCK,
    output reg SERIAL_DATA_OUT,
    output reg SERIAL_DATA_OE_N,
    input wire [RESULT_BITS-1:0] CORE_RESULT,
    input wire CORE_RESULT_VALID,
    output reg CORE_RESULT_READY,
    output reg SAMPLE_ACTIVE,
    output reg CONVERT_ACTIVE,
    output reg POWER_DOWN
);
    // one-hot sequencer states
    localparam [5:0] ST_SHUTDOWN = 6'h01;
    localparam [5:0] ST_SAMPLE = 6'h02;
    localparam [5:0] ST_NULL = 6'h04;
    localparam [5:0] ST_MSB_FIRST = 6'h08;
    localparam [5:0] ST_LSB_FIRST = 6'h10;
    localparam [5:0] ST_DONE = 6'h20;

    localparam [`EDGE_CNT_BITS-1:0] NULL_EDGE = `NULL_EDGE;
    localparam [`EDGE_CNT_BITS-1:0] LSB_FIRST_EDGE = `LSB_FIRST_EDGE;
    localparam [`EDGE_CNT_BITS-1:0] TRISTATE_EDGE = `TRISTATE_EDGE;
    // fill level at which the core port stops taking words
    localparam [4:0] FIFO_FULL = FIFO_DEPTH[4:0];

    wire sel_n_level;
    wire sel_fall;
    wire sclk_level;
    wire sclk_fall;
    wire [RESULT_BITS-1:0] fifo_data;
    wire fifo_valid;
    reg fifo_pop;
    reg [5:0] state_reg;
    reg [5:0] state_next;
    reg [`EDGE_CNT_BITS-1:0] edge_reg;
    reg [`EDGE_CNT_BITS-1:0] edge_next;
    reg [RESULT_BITS-1:0] word_reg;
    reg [RESULT_BITS-1:0] word_next;
    reg [4:0] bit_reg;
    reg [4:0] bit_next;
    reg dout_next;
    reg oe_n_next;
    // result queue bookkeeping and the mirrored word
    reg [4:0] fill_reg;
    reg [4:0] fill_next;
    wire fifo_room;
    wire core_take;
    wire [RESULT_BITS-1:0] word_rev;

    // select the bit of the held word at a given index
    function pick_bit;
        input [RESULT_BITS-1:0] word;
        input [4:0] idx;
        begin
            pick_bit = word[idx[3:0]];
        end
    endfunction

    // true when the falling edge now seen brings the count to the target
    function edge_hits;
        input [`EDGE_CNT_BITS-1:0] cnt;
        input [`EDGE_CNT_BITS-1:0] target;
        begin
            edge_hits = (cnt + 1'b1 == target);
        end
    endfunction

    // bit-mirrored copy of the held word for the lsb-first repeat
    genvar gi;
    generate
        for (gi = 0; gi < RESULT_BITS; gi = gi + 1) begin : g_mirror
            assign word_rev[gi] = word_reg[RESULT_BITS-1-gi];
        end
    endgenerate

    // select pin inverted then synchronised; idles low while deselected
    edge_sync #(
        .RESET_LEVEL(1'b0)
    ) u_sel_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .async_in(~SELECT_OR_SHUTDOWN_N),
        .level_out(sel_n_level),
        .rise_out(sel_fall),
        .fall_out()
    );

    // bit clock synchronised, falling edges found on the system clock
    edge_sync #(
        .RESET_LEVEL(1'b0)
    ) u_sclk_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .async_in(SERIAL_BIT_CLOCK),
        .level_out(sclk_level),
        .rise_out(),
        .fall_out(sclk_fall)
    );

    // result queue from the converter core toward the shifter
    result_fifo #(
        .WIDTH(RESULT_BITS),
        .DEPTH(FIFO_DEPTH),
        .AW(4)
    ) u_result_fifo (
        .clk(CLK),
        .rst_n(RST_N),
        .in_data(CORE_RESULT),
        .in_valid(core_take),
        .in_ready(fifo_room),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // a core word is taken only while the registered ready is up
    assign core_take = CORE_RESULT_VALID & CORE_RESULT_READY & fifo_room;

    // shadow of the fifo fill count, so ready can leave on a flop
    always @* begin
        fill_next = fill_reg;
        if (core_take && !fifo_pop) begin
            fill_next = fill_reg + 1'b1;
        end else if (fifo_pop && !core_take) begin
            fill_next = fill_reg - 1'b1;
        end
    end

    // ready drops at the same edge that fills the last free slot
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            fill_reg <= 5'h00;
            CORE_RESULT_READY <= 1'b0;
        end else begin
            fill_reg <= fill_next;
            CORE_RESULT_READY <= (fill_next != FIFO_FULL);
        end
    end

    // sequencer next state; sel_n_level is the inverted pin, high means selected
    always @* begin
        state_next = state_reg;
        edge_next = edge_reg;
        word_next = word_reg;
        bit_next = bit_reg;
        dout_next = SERIAL_DATA_OUT;
        oe_n_next = SERIAL_DATA_OE_N;
        fifo_pop = 1'b0;
        // a fresh fall shows one cycle before the synchronised level follows it
        if (!sel_n_level && !sel_fall) begin
            // select high: shutdown, counters held at start, output released
            state_next = ST_SHUTDOWN;
            edge_next = {`EDGE_CNT_BITS{1'b0}};
            bit_next = 5'h00;
            dout_next = 1'b0;
            oe_n_next = 1'b1;
        end else begin
            case (state_reg)
                ST_SHUTDOWN: begin
                    // only a fresh falling select leaves shutdown
                    if (sel_fall) begin
                        state_next = ST_SAMPLE;
                        edge_next = {`EDGE_CNT_BITS{1'b0}};
                    end
                end
                ST_SAMPLE: begin
                    // input sampled until the fifth falling edge
                    if (sclk_fall) begin
                        edge_next = edge_reg + 1'b1;
                        if (edge_hits(edge_reg, NULL_EDGE)) begin
                            state_next = ST_NULL;
                            dout_next = 1'b0;
                            oe_n_next = 1'b0;
                            fifo_pop = fifo_valid;
                            word_next = fifo_valid ? fifo_data : {RESULT_BITS{1'b0}};
                        end
                    end
                end
                ST_NULL: begin
                    // msb goes out on the falling edge ending the null bit
                    if (sclk_fall) begin
                        edge_next = edge_reg + 1'b1;
                        state_next = ST_MSB_FIRST;
                        bit_next = 5'h0E;
                        dout_next = word_reg[RESULT_BITS-1];
                    end
                end
                ST_MSB_FIRST: begin
                    // msb-first stream, one bit per falling edge
                    if (sclk_fall) begin
                        edge_next = edge_reg + 1'b1;
                        if (edge_hits(edge_reg, LSB_FIRST_EDGE)) begin
                            // lsb already out; repeat starts with bit one
                            state_next = ST_LSB_FIRST;
                            bit_next = 5'h01;
                            dout_next = pick_bit(word_reg, 5'h01);
                        end else begin
                            dout_next = pick_bit(word_reg, bit_reg);
                            bit_next = bit_reg - 1'b1;
                        end
                    end
                end
                ST_LSB_FIRST: begin
                    // lsb-first repeat, one bit per falling edge
                    if (sclk_fall) begin
                        edge_next = edge_reg + 1'b1;
                        if (edge_hits(edge_reg, TRISTATE_EDGE)) begin
                            state_next = ST_DONE;
                            oe_n_next = 1'b1;
                            dout_next = 1'b0;
                        end else begin
                            // stream position p is read from the mirror at msb index - p
                            bit_next = bit_reg + 1'b1;
                            dout_next = pick_bit(word_rev, 5'h0E - bit_reg);
                        end
                    end
                end
                ST_DONE: begin
                    // further clocks have no effect until select rises
                    state_next = ST_DONE;
                end
                default: begin
                    state_next = ST_SHUTDOWN;
                    oe_n_next = 1'b1;
                end
            endcase
        end
    end

    // sequencer registers and pin outputs
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= ST_SHUTDOWN;
            edge_reg <= {`EDGE_CNT_BITS{1'b0}};
            word_reg <= {RESULT_BITS{1'b0}};
            bit_reg <= 5'h00;
            SERIAL_DATA_OUT <= 1'b0;
            SERIAL_DATA_OE_N <= 1'b1;
        end else begin
            state_reg <= state_next;
            edge_reg <= edge_next;
            word_reg <= word_next;
            bit_reg <= bit_next;
            SERIAL_DATA_OUT <= dout_next;
            SERIAL_DATA_OE_N <= oe_n_next;
        end
    end

    // status flags decoded from the next state
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            SAMPLE_ACTIVE <= 1'b0;
            CONVERT_ACTIVE <= 1'b0;
            POWER_DOWN <= 1'b1;
        end else begin
            SAMPLE_ACTIVE <= (state_next == ST_SAMPLE);
            CONVERT_ACTIVE <= (state_next == ST_NULL) | (state_next == ST_MSB_FIRST);
            // power down when deselected, during the lsb-first repeat, or when done
            POWER_DOWN <= (state_next == ST_SHUTDOWN) | (state_next == ST_DONE) |
                (state_next == ST_LSB_FIRST);
        end
    end

    // clock level kept for reference of the sampling logic
    wire unused_level;
    assign unused_level = sclk_level;
endmodule // sar_adc_serial_readout
`default_nettype wire

// [shared/sar_adc_serial_readout_regs.vh]
// constants for the serial readout of the 16-bit sampling converter
// assumes inclusion by bare name from the design files
`ifndef SAR_ADC_SERIAL_READOUT_REGS_VH
`define SAR_ADC_SERIAL_READOUT_REGS_VH
// result width in bits
`define RESULT_BITS 16
// falling edge after which the null bit is driven
`define NULL_EDGE 5
// falling edge count at which the msb-first stream begins
`define MSB_FIRST_EDGE 6
// falling edge count at which the lsb-first repeat begins
`define LSB_FIRST_EDGE 22
// falling edge count at which the output tri-states
`define TRISTATE_EDGE 37
// edge counter width
`define EDGE_CNT_BITS 6
// code for midscale input
`define CODE_MIDSCALE 16'h8000
// code for full scale input
`define CODE_FULLSCALE 16'hFFFF
// fifo depth on the result path
`define RESULT_FIFO_DEPTH 16
// bench link clock period, ns
`define LINK_PERIOD_NS 400
// system clock period, ns
`define CLK_PERIOD_NS 50
`endif

// [rtl/edge_sync.v]
// two-stage synchroniser with rise and fall detection on the second stage
// assumes an asynchronous input and a free-running sampling clock
`timescale 1ns/100ps
`default_nettype none
module edge_sync #(
    parameter RESET_LEVEL = 1'b0
) (
    input wire clk,
    input wire rst_n,
    input wire async_in,
    output reg level_out,
    output wire rise_out,
    output wire fall_out
);
    reg meta_reg;
    reg sync_reg;
    // two flops, then a delayed copy for edge detection
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= RESET_LEVEL;
            sync_reg <= RESET_LEVEL;
            level_out <= RESET_LEVEL;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
            level_out <= sync_reg;
        end
    end
    // edges seen between second stage and its delayed copy
    assign rise_out = sync_reg & ~level_out;
    assign fall_out = ~sync_reg & level_out;
endmodule // edge_sync
`default_nettype wire

// [rtl/result_fifo.v]
// small flip-flop fifo with valid/ready on both sides
// assumes one clock; reads and writes in the same cycle are allowed
`timescale 1ns/100ps
`default_nettype none
module result_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire rst_n,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wr_reg;
    reg [AW-1:0] rd_reg;
    reg [AW:0] cnt_reg;
    wire push;
    wire pop;
    assign in_ready = (cnt_reg != DEPTH[AW:0]);
    assign out_valid = (cnt_reg != {(AW+1){1'b0}});
    assign out_data = mem_reg[rd_reg];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    // storage write
    always @(posedge clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end
    // pointers and fill count
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg <= {AW{1'b0}};
            rd_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule // result_fifo
`default_nettype wire

// [testbench/readout_props.sv]
// port assertions for the serial readout sequencer
// assumes select high through reset, bound to the top below
`timescale 1ns/100ps
`default_nettype none
module readout_props #(
    parameter int RESULT_BITS = 16
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic SELECT_OR_SHUTDOWN_N,
    input wire logic SERIAL_BIT_CLOCK,
    input wire logic SERIAL_DATA_OUT,
    input wire logic SERIAL_DATA_OE_N,
    input wire logic [RESULT_BITS-1:0] CORE_RESULT,
    input wire logic CORE_RESULT_VALID,
    input wire logic CORE_RESULT_READY,
    input wire logic SAMPLE_ACTIVE,
    input wire logic CONVERT_ACTIVE,
    input wire logic POWER_DOWN
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // shutdown and initial state while select is high
    idle_when_high_a: assert property (SELECT_OR_SHUTDOWN_N [*7] |-> SERIAL_DATA_OE_N
        && POWER_DOWN && !SAMPLE_ACTIVE && !CONVERT_ACTIVE) else $error("not idle");
    abort_release_a: assert property ($rose(SELECT_OR_SHUTDOWN_N) |->
        ##[1:5] SERIAL_DATA_OE_N) else $error("abort left output on");
    start_on_fall_a: assert property ($rose(SAMPLE_ACTIVE) |->
        !SELECT_OR_SHUTDOWN_N && $past(SELECT_OR_SHUTDOWN_N, 6)) else $error("bad start");
    sample_phase_a: assert property (SAMPLE_ACTIVE |->
        !POWER_DOWN && SERIAL_DATA_OE_N) else $error("sample phase wrong");
    null_low_a: assert property ($fell(SERIAL_DATA_OE_N) |->
        !SERIAL_DATA_OUT && CONVERT_ACTIVE) else $error("null bit not low");
    null_length_a: assert property ($fell(SERIAL_DATA_OE_N) |->
        (!SERIAL_DATA_OUT) [*7]) else $error("null bit too short");
    change_on_fall_a: assert property ($changed(SERIAL_DATA_OUT) && !SERIAL_DATA_OE_N |->
        !$past(SERIAL_BIT_CLOCK, 2)) else $error("data moved off a falling edge");
    tristate_hold_a: assert property ($rose(SERIAL_DATA_OE_N) && !SELECT_OR_SHUTDOWN_N |=>
        SERIAL_DATA_OE_N [*8]) else $error("output woke after tristate");
    convert_awake_a: assert property (CONVERT_ACTIVE |->
        !SAMPLE_ACTIVE && !POWER_DOWN) else $error("convert phase wrong");
    // main scenarios reached
    cover property ($rose(SERIAL_DATA_OE_N) && !SELECT_OR_SHUTDOWN_N);
    cover property ($rose(SELECT_OR_SHUTDOWN_N) && !SERIAL_DATA_OE_N);
    cover property (CORE_RESULT_VALID && !CORE_RESULT_READY);
endmodule // readout_props
bind sar_adc_serial_readout readout_props #(.RESULT_BITS(RESULT_BITS)) i_readout_props (
    .CLK(CLK), .RST_N(RST_N), .SELECT_OR_SHUTDOWN_N(SELECT_OR_SHUTDOWN_N),
    .SERIAL_BIT_CLOCK(SERIAL_BIT_CLOCK), .SERIAL_DATA_OUT(SERIAL_DATA_OUT),
    .SERIAL_DATA_OE_N(SERIAL_DATA_OE_N), .CORE_RESULT(CORE_RESULT),
    .CORE_RESULT_VALID(CORE_RESULT_VALID), .CORE_RESULT_READY(CORE_RESULT_READY),
    .SAMPLE_ACTIVE(SAMPLE_ACTIVE), .CONVERT_ACTIVE(CONVERT_ACTIVE), .POWER_DOWN(POWER_DOWN));
`default_nettype wire

// [testbench/host_port_model.sv]
// host serial port: drives select and a 400 ns bit clock, captures data
// assumes the bench calls frame() and collects res_data on each res_stb
`timescale 1ns/100ps
`default_nettype none
module host_port_model (
    output logic sel_n,
    output logic sclk,
    input wire logic dout,
    input wire logic oe_n,
    output logic res_stb,
    output logic [15:0] res_data
);
    logic last = 1'b0;
    logic line;
    // a released line shows the inverse of its last driven level
    always @* if (!oe_n) last = dout;
    always @* line = oe_n ? ~last : dout;
    initial begin
        sel_n = 1'b1;
        sclk = 1'b0;
        res_stb = 1'b0;
        res_data = 16'h0000;
    end
    // hand one captured word to the bench
    task emit(input logic [15:0] v);
        res_data = v;
        res_stb = 1'b1;
        #1 res_stb = 1'b0;
        #1;
    endtask
    // one frame of n clocks; clock idles low, bit taken late in the high phase
    task frame(input int n);
        logic [15:0] w;
        logic [15:0] r;
        logic [15:0] st;
        w = 16'h0000;
        r = 16'h0000;
        st = 16'h0000;
        sel_n = 1'b0;
        for (int k = 1; k <= n; k++) begin
            #200 sclk = 1'b1;
            #190;
            if (k == 5) st[2] = oe_n;
            if (k == 6) st[1] = line;
            if (k >= 7 && k <= 22) w = {w[14:0], line};
            if (k >= 22 && k <= 37) r = {line, r[15:1]};
            if (k == 38) st[0] = oe_n;
            #10 sclk = 1'b0;
        end
        #200 sel_n = 1'b1;
        if (n >= 7) emit(w);
        if (n >= 37) emit(r);
        if (n >= 38) emit(st);
        #10000;
    endtask
endmodule // host_port_model
`default_nettype wire

// [testbench/sar_adc_serial_readout_tb.sv]
// self-checking bench: fills the result fifo, then runs full and cut frames
// assumes the design, the constants header and the host port model
`timescale 1ns/100ps
`default_nettype none
`include "sar_adc_serial_readout_regs.vh"
module sar_adc_serial_readout_tb;
    logic clk = 1'b0;
    logic rst_n, sel_n, sclk, dout, oe_n, core_valid, core_ready;
    logic sample_active, convert_active, power_down, res_stb;
    logic [15:0] core_result, res_data;
    logic [15:0] exp_q[$];
    logic [15:0] fifo_q[$];
    int failures = 0;
    int compares = 0;
    int seed;
    // 20 MHz system clock
    always #25 clk = ~clk;
    sar_adc_serial_readout i_sar_adc_serial_readout (.CLK(clk), .RST_N(rst_n),
        .SELECT_OR_SHUTDOWN_N(sel_n), .SERIAL_BIT_CLOCK(sclk), .SERIAL_DATA_OUT(dout),
        .SERIAL_DATA_OE_N(oe_n), .CORE_RESULT(core_result), .CORE_RESULT_VALID(core_valid),
        .CORE_RESULT_READY(core_ready), .SAMPLE_ACTIVE(sample_active),
        .CONVERT_ACTIVE(convert_active), .POWER_DOWN(power_down));
    host_port_model i_host_port_model (.sel_n(sel_n), .sclk(sclk), .dout(dout),
        .oe_n(oe_n), .res_stb(res_stb), .res_data(res_data));
    // counts, verdict and end of run
    task print_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one word into the result fifo on a bounded handshake
    task push(input logic [15:0] v);
        int t;
        t = 0;
        @(negedge clk);
        core_result = v;
        core_valid = 1'b1;
        while (core_ready !== 1'b1 && t < 20) begin
            @(negedge clk);
            t++;
        end
        if (t == 20) begin
            failures++;
            print_verdict;
        end
        @(negedge clk);
        fifo_q.push_back(v);
        core_valid = 1'b0;
    endtask
    // expected words of one frame, then the frame itself
    task run(input int n);
        logic [15:0] w;
        w = 16'h0000;
        if (n >= 5 && fifo_q.size() > 0) w = fifo_q.pop_front();
        if (n >= 7) exp_q.push_back(n >= 22 ? w : w >> (22 - n));
        if (n >= 37) exp_q.push_back(w);
        if (n >= 38) exp_q.push_back(16'h0005);
        @(negedge clk);
        #13;
        fork
            i_host_port_model.frame(n);
            begin
                #300 chk({13'h0000, sample_active, convert_active, power_down}, 16'h0004);
                if (n >= 6) begin
                    #2000 chk({11'h000, sample_active, convert_active, power_down, oe_n, dout},
                        16'h0008);
                end
            end
        join
        chk({12'h000, sample_active, convert_active, power_down, oe_n}, 16'h0003);
    endtask
    // each captured word against the oldest expectation
    always @(posedge res_stb) begin
        if (exp_q.size() == 0) chk(res_data, 16'hDEAD);
        else chk(res_data, exp_q.pop_front());
    end
    initial begin
        #2000000;
        failures++;
        print_verdict;
    end
    initial begin
        seed = $urandom(32'h0E4D);
        rst_n = 1'b0;
        core_result = 16'h0000;
        core_valid = 1'b0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        repeat (5) @(negedge clk);
        chk({14'h0000, oe_n, power_down}, 16'h0003);
        push(`CODE_MIDSCALE);
        push(`CODE_FULLSCALE);
        push(16'h0000);
        for (int i = 3; i < 16; i++) push(16'($urandom));
        @(negedge clk);
        core_result = 16'h1234;
        core_valid = 1'b1;
        repeat (3) @(negedge clk);
        chk({15'h0000, core_ready}, 16'h0000);
        core_valid = 1'b0;
        run(38);
        run(38);
        run(22);
        run(3);
        run(14);
        run(7);
        run(37);
        for (int i = 0; i < 12; i++) run(7 + $urandom % 32);
        repeat (10) @(negedge clk);
        chk(16'(exp_q.size()), 16'h0000);
        print_verdict;
    end
endmodule // sar_adc_serial_readout_tb
`default_nettype wire
